// ==== design/pcg_pkg.sv ====
package pcg_pkg;

    // Byte address of the configuration dword that holds the command word (low half) and status word (high half).
    localparam logic [7:0]  PCG_CMD_DWORD_ADDR   = 8'h04;

    // Bit positions inside the command word.
    localparam int          PCG_BIT_PORT_WIN     = 0;
    localparam int          PCG_BIT_MEM_WIN      = 1;
    localparam int          PCG_BIT_INITIATOR    = 2;
    localparam int          PCG_BIT_BCAST_MON    = 3;
    localparam int          PCG_BIT_INV_WRITE    = 4;
    localparam int          PCG_BIT_PALETTE      = 5;
    localparam int          PCG_BIT_PARITY       = 6;
    localparam int          PCG_BIT_STEPPING     = 7;
    localparam int          PCG_BIT_SYS_ERR      = 8;
    localparam int          PCG_BIT_B2B          = 9;
    localparam int          PCG_BIT_INT_MASK     = 10;

    // Position of the pending interrupt flag inside the status word.
    localparam int          PCG_STAT_BIT_INT     = 3;

    // Bits that software may change; every other bit is fixed.
    localparam logic [15:0] PCG_CMD_WR_MASK      = 16'h0557;
    // Value held by the writable bits after reset.
    localparam logic [15:0] PCG_CMD_RESET        = 16'h0000;
    // Fixed values of the read-only bits (monitor, snoop, stepping, back-to-back, reserved).
    localparam logic [15:0] PCG_CMD_RO_VALUE     = 16'h0000;

    // Power state code of the fully powered state.
    localparam logic [1:0]  PCG_PM_D0            = 2'h0;

    // Zero word returned for any dword this block does not own.
    localparam logic [31:0] PCG_RDATA_NONE       = 32'h0000_0000;

    // Power states as encoded by the power management logic.
    typedef enum logic [1:0] {
        PCG_D0 = 2'b00,
        PCG_D1 = 2'b01,
        PCG_D2 = 2'b10,
        PCG_D3 = 2'b11
    } pcg_pm_e;

    // Command word laid out bit by bit, bit 15 first.
    typedef struct packed {
        logic [4:0] reserved;
        logic       interrupt_mask;
        logic       back_to_back_permit;
        logic       system_error_permit;
        logic       addr_data_stepping;
        logic       parity_reaction_enable;
        logic       palette_snoop_ctrl;
        logic       invalidate_write_permit;
        logic       broadcast_cycle_monitor;
        logic       initiator_enable;
        logic       mem_window_enable;
        logic       port_window_enable;
    } pcg_cmd_s;

    // One configuration access as decoded by the PCI target front end.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcg_cfg_req_s;

    // Non-configuration bus events presented by the PCI front end and the MAC.
    typedef struct packed {
        logic io_hit;
        logic rom_hit;
        logic bcast_cycle;
        logic master_req;
        logic inv_write_req;
        logic parity_err;
        logic sys_err_event;
    } pcg_bus_ev_s;

    // Permissions and acknowledges returned to the front end.
    typedef struct packed {
        logic io_accept;
        logic rom_accept;
        logic bcast_accept;
        logic master_grant;
        logic inv_write_ok;
        logic parity_report;
    } pcg_bus_gate_s;

endpackage

// ==== design/pcg_cmd_reg.sv ====
`timescale 1ns/1ps
`default_nettype none

// Storage for the command word; only writable bits hold flip-flops' worth of state.
module pcg_cmd_reg
    import pcg_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        wr_en_i,
    input  wire logic [1:0]  be_i,
    input  wire logic [15:0] wdata_i,
    output pcg_cmd_s         cmd_o
);

    // All state of this module.
    typedef struct packed {
        logic [15:0] word;
    } pcg_cmd_state_s;

    pcg_cmd_state_s state_q;   // Registered state.
    pcg_cmd_state_s state_d;   // Next state.
    logic [15:0]    lane_mask; // Bits covered by the enabled byte lanes.

    // Merge a write into the writable bits; fixed bits never take written data.
    always_comb
    begin
        state_d   = state_q;
        lane_mask = {{8{be_i[1]}}, {8{be_i[0]}}};
        if (wr_en_i)
        begin
            // Only bits in both the lane mask and the writable mask change.
            state_d.word = (state_q.word & ~(lane_mask & PCG_CMD_WR_MASK))
                         | (wdata_i & lane_mask & PCG_CMD_WR_MASK);
        end
    end

    // Writable bits clear on reset so the device starts fully disabled.
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_q.word <= PCG_CMD_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Read-only and reserved bits come from constants, never from storage.
    assign cmd_o = pcg_cmd_s'((state_q.word & PCG_CMD_WR_MASK) | (PCG_CMD_RO_VALUE & ~PCG_CMD_WR_MASK));

endmodule

`default_nettype wire

// ==== design/pcg_od_pin.sv ====
`timescale 1ns/1ps
`default_nettype none

// Registered open-drain driver: the pin is either pulled low or released.
module pcg_od_pin
    import pcg_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic drive_i,
    output logic      pin_o,
    output logic      pin_oe_o
);

    // All state of this module.
    typedef struct packed {
        logic drive;
    } pcg_od_state_s;

    pcg_od_state_s state_q; // Registered state.
    pcg_od_state_s state_d; // Next state.

    // Next drive level follows the request.
    always_comb
    begin
        state_d       = state_q;
        state_d.drive = drive_i;
    end

    // Pin released during reset.
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_q.drive <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // An open-drain pin only ever drives low, so the data level is constant.
    assign pin_o    = 1'b0;
    assign pin_oe_o = state_q.drive;

endmodule

`default_nettype wire

// ==== design/pcg_cmd_gate.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - All control bits zero: only configuration cycles.
// - Port accesses need port window bit and D0.
// - ROM decode needs memory bit, ROM enable, D0.
// - Mastering needs initiator bit and D0.
// - Broadcast monitor bit reads zero; ignore broadcasts.
// - Invalidate writes only with permit bit set.
// - Palette snoop bit read-only zero; normal palette handling.
// - Parity errors reported only with reaction bit.
// - Stepping bit hardwired; this device never steps.
// - System error pin moves only when permitted.
// - Back-to-back bit read-only; same agent only.
// - Interrupt mask set keeps interrupt pin inactive.
// - Reserved bits 15..11 written zero, read zero.
// - Interrupt pin equals pending and not masked.
module pcg_cmd_gate
    import pcg_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire pcg_cfg_req_s  cfg_req_i,
    output logic               cfg_ack_o,
    output logic [31:0]        cfg_rdata_o,
    input  wire pcg_pm_e       pm_state_i,
    input  wire logic          rom_decode_enable_i,
    input  wire logic          pending_interrupt_flag_i,
    input  wire pcg_bus_ev_s   bus_ev_i,
    output pcg_bus_gate_s      bus_gate_o,
    output logic               bus_detached_o,
    output pcg_cmd_s           cmd_o,
    output logic               interrupt_out_n_o,
    output logic               interrupt_out_n_oe_o,
    output logic               system_error_out_n_o,
    output logic               system_error_out_n_oe_o
);

    // All state of the top level: answers to the configuration port and to the bus front end.
    typedef struct packed {
        logic          cfg_ack;
        logic [31:0]   cfg_rdata;
        pcg_bus_gate_s gate;
        logic          detached;
    } pcg_top_state_s;

    pcg_top_state_s state_q;      // Registered state.
    pcg_top_state_s state_d;      // Next state.
    pcg_cmd_s       cmd;          // Current command word, fixed bits included.
    logic           cmd_hit;      // Access targets the command dword.
    logic           cmd_wr;       // Write to the command dword.
    logic           in_d0;        // Device is fully powered.
    logic           int_drive;    // Request to pull the interrupt pin low.
    logic           sys_err_drive; // Request to pull the system error pin low.
    logic [15:0]    status_word;  // Status half of the dword, only the interrupt flag here.

    // The command dword is recognised by its byte address; other dwords belong to other blocks.
    assign cmd_hit = (cfg_req_i.addr[7:2] == PCG_CMD_DWORD_ADDR[7:2]);

    // Configuration writes are taken whatever the power state, as configuration space must stay reachable.
    assign cmd_wr = cfg_req_i.wr && cmd_hit;

    // Only D0 allows port or ROM decoding and mastering.
    assign in_d0 = (pm_state_i == PCG_D0);

    // Command word storage with its byte lanes.
    // Reset clearing and the masking of fixed bits both live inside the storage.
    pcg_cmd_reg u_cmd_reg
    (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .wr_en_i (cmd_wr),
        .be_i    (cfg_req_i.be[1:0]),
        .wdata_i (cfg_req_i.wdata[15:0]),
        .cmd_o   (cmd)
    );

    // The status half shows only the pending interrupt flag; the full status register lives elsewhere.
    always_comb
    begin
        status_word                    = 16'h0000;
        status_word[PCG_STAT_BIT_INT]  = pending_interrupt_flag_i;
    end

    // Next state of the configuration answer and the bus gating.
    always_comb
    begin
        state_d = state_q;

        // Every configuration access is answered one cycle later, hit or not.
        state_d.cfg_ack = cfg_req_i.rd || cfg_req_i.wr;

        // Read data is held until the next read so the front end may sample it late.
        if (cfg_req_i.rd)
        begin
            if (cmd_hit)
            begin
                // Reserved and read-only bits come back at their fixed values.
                state_d.cfg_rdata = {status_word, cmd};
            end
            else
            begin
                // Dwords not owned here read as zero.
                state_d.cfg_rdata = PCG_RDATA_NONE;
            end
        end

        // With no control bit set the device behaves as if unplugged, except for configuration and the interrupt pin, which still follows the pending flag.
        state_d.detached = ((cmd & PCG_CMD_WR_MASK) == 16'h0000);

        // Port space decode requires the window bit and full power.
        state_d.gate.io_accept = bus_ev_i.io_hit && cmd.port_window_enable && in_d0;

        // Expansion ROM decode needs both enables and full power.
        state_d.gate.rom_accept = bus_ev_i.rom_hit && cmd.mem_window_enable && rom_decode_enable_i && in_d0;

        // Broadcast cycles pass only if the fixed monitor bit were one; here it is zero.
        state_d.gate.bcast_accept = bus_ev_i.bcast_cycle && cmd.broadcast_cycle_monitor;

        // Starting a master transaction needs the initiator bit and full power.
        state_d.gate.master_grant = bus_ev_i.master_req && cmd.initiator_enable && in_d0;

        // The invalidate write command may be used only with the permit bit, the initiator bit and full power; no master request is needed.
        state_d.gate.inv_write_ok = bus_ev_i.inv_write_req && cmd.invalidate_write_permit
                                  && cmd.initiator_enable && in_d0;

        // Detected parity errors are reported only while reaction is enabled, otherwise dropped.
        state_d.gate.parity_report = bus_ev_i.parity_err && cmd.parity_reaction_enable;
    end

    // Registered outputs start cleared and the detached flag set, so no access is accepted before configuration.
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_q.cfg_ack   <= 1'b0;
            state_q.cfg_rdata <= 32'h0000_0000;
            state_q.gate      <= '0;
            state_q.detached  <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // The interrupt pin follows the pending flag unless masked; masking does not touch the flag itself.
    assign int_drive = pending_interrupt_flag_i && !cmd.interrupt_mask;

    // A masked interrupt never reaches the pin driver.
    pcg_od_pin u_int_pin
    (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .drive_i  (int_drive),
        .pin_o    (interrupt_out_n_o),
        .pin_oe_o (interrupt_out_n_oe_o)
    );

    // The system error pin may only change while permitted; otherwise its driver stays idle.
    assign sys_err_drive = bus_ev_i.sys_err_event && cmd.system_error_permit;

    // System error is an open-drain pulse as long as the event lasts.
    pcg_od_pin u_serr_pin
    (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .drive_i  (sys_err_drive),
        .pin_o    (system_error_out_n_o),
        .pin_oe_o (system_error_out_n_oe_o)
    );

    // The command word is exported so the master logic can read the fixed capability bits.
    // Back-to-back permit reads zero, so the master must keep fast back-to-back to one agent.
    // Stepping reads zero because this device never steps addresses or data.
    // Palette snoop reads zero, so palette writes are decoded like any other write.
    assign cmd_o = cmd;

    // Registered answers to the configuration port.
    assign cfg_ack_o   = state_q.cfg_ack;
    assign cfg_rdata_o = state_q.cfg_rdata;

    // Registered answers to the bus front end.
    assign bus_gate_o     = state_q.gate;
    assign bus_detached_o = state_q.detached;

endmodule

`default_nettype wire

// ==== verif/pcg_cmd_gate_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

// Port checks of the command gating; every gate lags its cause by one edge.
module pcg_cmd_gate_chk
    import pcg_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire pcg_cfg_req_s  cfg_req_i,
    input  wire logic          cfg_ack_o,
    input  wire pcg_pm_e       pm_state_i,
    input  wire logic          rom_decode_enable_i,
    input  wire logic          pending_interrupt_flag_i,
    input  wire pcg_bus_ev_s   bus_ev_i,
    input  wire pcg_bus_gate_s bus_gate_o,
    input  wire logic          bus_detached_o,
    input  wire pcg_cmd_s      cmd_o,
    input  wire logic          interrupt_out_n_oe_o,
    input  wire logic          system_error_out_n_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // High while the device is in the fully powered state.
    wire logic d0 = (pm_state_i == PCG_D0);

    // The past check is skipped on the first edge after reset, when the gates were still held clear.
    property p_detach; $past(rst_n_i) |-> bus_detached_o == $past((cmd_o & PCG_CMD_WR_MASK) == 16'h0000); endproperty
    a_detach: assert property (p_detach) else $error("detached flag wrong");
    property p_io; $past(rst_n_i) |-> bus_gate_o.io_accept == $past(bus_ev_i.io_hit & cmd_o[0] & d0); endproperty
    a_io: assert property (p_io) else $error("port gate wrong");
    property p_rom;
        $past(rst_n_i) |-> bus_gate_o.rom_accept == $past(bus_ev_i.rom_hit & cmd_o[1] & rom_decode_enable_i & d0);
    endproperty
    a_rom: assert property (p_rom) else $error("rom gate wrong");
    property p_mst; $past(rst_n_i) |-> bus_gate_o.master_grant == $past(bus_ev_i.master_req & cmd_o[2] & d0); endproperty
    a_mst: assert property (p_mst) else $error("master gate wrong");
    property p_bcast; !bus_gate_o.bcast_accept && !cmd_o.broadcast_cycle_monitor; endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast accepted");
    property p_inv;
        $past(rst_n_i) |-> bus_gate_o.inv_write_ok == $past(bus_ev_i.inv_write_req & cmd_o[4] & cmd_o[2] & d0);
    endproperty
    a_inv: assert property (p_inv) else $error("invalidate write without permit");
    property p_par; $past(rst_n_i) |-> bus_gate_o.parity_report == $past(bus_ev_i.parity_err & cmd_o[6]); endproperty
    a_par: assert property (p_par) else $error("parity report wrong");
    property p_ro; (cmd_o & ~PCG_CMD_WR_MASK) == PCG_CMD_RO_VALUE; endproperty
    a_ro: assert property (p_ro) else $error("fixed bits moved");
    property p_serr;
        $past(rst_n_i) |-> system_error_out_n_oe_o == $past(bus_ev_i.sys_err_event & cmd_o[8]);
    endproperty
    a_serr: assert property (p_serr) else $error("system error pin wrong");
    property p_int;
        $past(rst_n_i) |-> interrupt_out_n_oe_o == $past(pending_interrupt_flag_i & !cmd_o[10]);
    endproperty
    a_int: assert property (p_int) else $error("interrupt pin wrong");
    property p_ack; (cfg_req_i.rd || cfg_req_i.wr) |=> cfg_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("config access not answered");
endmodule

bind pcg_cmd_gate pcg_cmd_gate_chk pcg_cmd_gate_chk_inst (.mclk_i, .rst_n_i, .cfg_req_i, .cfg_ack_o,
    .pm_state_i, .rom_decode_enable_i, .pending_interrupt_flag_i, .bus_ev_i, .bus_gate_o,
    .bus_detached_o, .cmd_o, .interrupt_out_n_oe_o, .system_error_out_n_oe_o);

`default_nettype wire

// ==== verif/pcg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Host bridge side: issues configuration cycles to the command dword.
module pcg_host_model
    import pcg_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         cfg_ack_i,
    input  wire logic [31:0]  cfg_rdata_i,
    output var  pcg_cfg_req_s cfg_req_o
);
    initial cfg_req_o = '0;

    // One access: a single-cycle request, answer taken in the acknowledge cycle.
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
                          input logic [31:0] d, output logic k, output logic [31:0] q);
        @(posedge mclk_i);
        cfg_req_o <= '{rd: !w, wr: w, addr: a, be: b, wdata: d};
        @(posedge mclk_i);
        // Released qualifiers flip, so stale address or data never looks valid.
        cfg_req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~b, wdata: ~d};
        // The answer is taken at the edge that closes the acknowledge cycle, before that edge updates it.
        @(posedge mclk_i);
        k = cfg_ack_i;
        q = cfg_rdata_i;
    endtask
endmodule

`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the command register and its gating.
module tb;
    import pcg_pkg::*;
    logic          mclk_i, rst_n_i, rom_decode_enable_i, pending_interrupt_flag_i;
    pcg_pm_e       pm_state_i;
    pcg_bus_ev_s   bus_ev_i;
    pcg_cfg_req_s  cfg_req_i;
    logic          cfg_ack_o, bus_detached_o;
    logic [31:0]   cfg_rdata_o;
    pcg_bus_gate_s bus_gate_o;
    pcg_cmd_s      cmd_o;
    logic          interrupt_out_n_o, interrupt_out_n_oe_o, system_error_out_n_o, system_error_out_n_oe_o;
    int            n_fail, checks_done;
    // Command words tried against every event; 0010 has invalidate permit but no initiator.
    logic [15:0]   cl [4] = '{16'h0000, 16'h0557, 16'h0010, 16'h0145};

    pcg_cmd_gate pcg_cmd_gate_inst (.mclk_i, .rst_n_i, .cfg_req_i, .cfg_ack_o, .cfg_rdata_o, .pm_state_i,
        .rom_decode_enable_i, .pending_interrupt_flag_i, .bus_ev_i, .bus_gate_o, .bus_detached_o, .cmd_o,
        .interrupt_out_n_o, .interrupt_out_n_oe_o, .system_error_out_n_o, .system_error_out_n_oe_o);
    pcg_host_model pcg_host_model_inst (.mclk_i, .cfg_ack_i(cfg_ack_o), .cfg_rdata_i(cfg_rdata_o),
        .cfg_req_o(cfg_req_i));

    // Free-running 25 MHz clock.
    initial
    begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // Counts every comparison; a mismatch is reported at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        logic        k;
        logic [31:0] q;
        pcg_host_model_inst.access(1'b1, a, b, d, k, q);
        chk(32'(k), 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic        k;
        logic [31:0] q;
        pcg_host_model_inst.access(1'b0, a, 4'hf, 32'h0, k, q);
        chk(32'(k), 32'h1);
        chk(q, e);
    endtask

    // One-cycle event; the expected gates are worked out here, not taken from the design.
    task automatic pulse(input pcg_bus_ev_s e, input logic [15:0] c, input logic d0, input logic re);
        pcg_bus_gate_s g;
        g.io_accept     = e.io_hit & c[0] & d0;
        g.rom_accept    = e.rom_hit & c[1] & re & d0;
        g.bcast_accept  = 1'b0;
        g.master_grant  = e.master_req & c[2] & d0;
        g.inv_write_ok  = e.inv_write_req & c[4] & c[2] & d0;
        g.parity_report = e.parity_err & c[6];
        @(posedge mclk_i);
        bus_ev_i <= e;
        @(posedge mclk_i);
        bus_ev_i <= '0;
        @(negedge mclk_i);
        chk(32'(bus_gate_o), 32'(g));
        chk(32'(system_error_out_n_oe_o), 32'(e.sys_err_event & c[8]));
    endtask

    // Main sequence; reset is held for six edges first.
    initial
    begin
        rst_n_i = 1'b0;
        pm_state_i = PCG_D0;
        rom_decode_enable_i = 1'b1;
        pending_interrupt_flag_i = 1'b0;
        bus_ev_i = '0;
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(8'h04, 32'h0);
        chk(32'(bus_detached_o), 32'h1);
        $display("end of test reset");
        wr(8'h04, 4'h3, 32'h0000_07ff);
        rd(8'h04, 32'h0000_0557);
        chk(32'(cmd_o), 32'h0000_0557);
        wr(8'h04, 4'h2, 32'h0);
        rd(8'h04, 32'h0000_0057);
        wr(8'h08, 4'hf, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h0000_0057);
        $display("end of test access");
        foreach (cl[k])
        begin
            wr(8'h04, 4'h3, {16'h0, cl[k]});
            for (int p = 0; p < 2; p++)
            begin
                for (int r = 0; r < 2; r++)
                begin
                    @(posedge mclk_i);
                    pm_state_i <= p[0] ? PCG_D3 : PCG_D0;
                    rom_decode_enable_i <= r[0];
                    for (int i = 0; i < 7; i++)
                        pulse(pcg_bus_ev_s'(7'h1 << i), cl[k], p == 0, r[0]);
                end
            end
            chk(32'(bus_detached_o), 32'(cl[k] == 16'h0));
        end
        chk(32'(system_error_out_n_o), 32'h0);
        $display("end of test gates");
        @(posedge mclk_i);
        pm_state_i <= PCG_D0;
        pending_interrupt_flag_i <= 1'b1;
        wr(8'h04, 4'h3, 32'h0);
        @(negedge mclk_i);
        chk(32'(interrupt_out_n_oe_o), 32'h1);
        wr(8'h04, 4'h3, 32'h0400);
        @(negedge mclk_i);
        chk(32'(interrupt_out_n_oe_o), 32'h0);
        chk(32'(interrupt_out_n_o), 32'h0);
        rd(8'h04, 32'h0008_0400);
        $display("end of test interrupt");
        // A reset in mid-run must bring every writable bit back to zero.
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(8'h04, 32'h0008_0000);
        $display("end of test second reset");
        close_out();
    end

    // Watchdog: the sequence needs well under 2000 cycles.
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        close_out();
    end
endmodule

`default_nettype wire
